// ===== src/dio_cfg.svh
`ifndef DIO_CFG_SVH
`define DIO_CFG_SVH

// Clock rate and filter timing
`define DIO_CLK_HZ        40000000
`define DIO_FILT_UNIT_MS  1
`define DIO_FILT_MAX_MS   163
`define DIO_MS_CYCLES     ((`DIO_CLK_HZ / 1000) * `DIO_FILT_UNIT_MS)

// Register byte offsets
`define DIO_OFS_IN_MODE   8'h00
`define DIO_OFS_FILT_MS   8'h04
`define DIO_OFS_IN_LEVEL  8'h08
`define DIO_OFS_EDGE_PEND 8'h0C
`define DIO_OFS_ISO_LATCH 8'h10
`define DIO_OFS_OUT_CMD   8'h14
`define DIO_OFS_OUT_SEL   8'h18
`define DIO_OFS_OUT_POL   8'h1C
`define DIO_OFS_EN_SEL    8'h20
`define DIO_OFS_EN_VAL    8'h24
`define DIO_OFS_EN_POL    8'h28
`define DIO_OFS_OUT_STATE 8'h2C

// Field layout
`define DIO_MODE_W        2
`define DIO_CMD_W         2
`define DIO_SEL_W         4
`define DIO_SEL_FOLLOW    3
`define DIO_ISO_DATA_W    5
`define DIO_FILT_W        8
`define DIO_OUT_STATE_EN  8

// Reset values
`define DIO_RST_WORD      32'h0000_0000
`define DIO_RST_FILT      8'h00

`endif

// ===== src/dio_pkg.sv
package dio_pkg;
   // Input line behaviour, encoded in two bits per line
   typedef enum logic [1:0] {
      IN_LEVEL,
      IN_ANY_EDGE,
      IN_RISE_EDGE,
      IN_FALL_EDGE
   } in_mode_t;

   // Output command, two bits per line
   typedef enum logic [1:0] {
      CMD_NONE,
      CMD_LOW,
      CMD_HIGH,
      CMD_TOGGLE
   } out_cmd_t;
endpackage

// ===== src/line_filter.sv
`timescale 1ns/100ps
`include "dio_cfg.svh"

module line_filter (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       pin,
   input  wire logic       ms_tick,
   input  wire logic [7:0] width_ms,
   output logic            level,
   output logic            rise,
   output logic            fall
);
   logic       s1_r, s2_r, s3_r;
   logic       lvl_r, lvl_nxt;
   logic       rise_r, rise_nxt;
   logic       fall_r, fall_nxt;
   logic [7:0] cnt_r, cnt_nxt;

   // Qualify a new level only after it outlasts the filter width
   always_comb begin
      lvl_nxt  = lvl_r;
      cnt_nxt  = cnt_r;
      rise_nxt = 1'b0;
      fall_nxt = 1'b0;
      if ((s2_r == s3_r) && (s3_r != lvl_r)) begin
         if (cnt_r >= width_ms) begin
            lvl_nxt  = s3_r;
            cnt_nxt  = 8'h00;
            rise_nxt = s3_r;
            fall_nxt = ~s3_r;
         end else if (ms_tick) begin
            cnt_nxt = cnt_r + 8'h01;
         end
      end else begin
         cnt_nxt = 8'h00;                      // short excursion dropped
      end
   end

   // Three-stage synchroniser and filter state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r   <= 1'b0;
         s2_r   <= 1'b0;
         s3_r   <= 1'b0;
         lvl_r  <= 1'b0;
         cnt_r  <= 8'h00;
         rise_r <= 1'b0;
         fall_r <= 1'b0;
      end else begin
         s1_r   <= pin;
         s2_r   <= s1_r;
         s3_r   <= s2_r;
         lvl_r  <= lvl_nxt;
         cnt_r  <= cnt_nxt;
         rise_r <= rise_nxt;
         fall_r <= fall_nxt;
      end
   end

   assign level = lvl_r;
   assign rise  = rise_r;
   assign fall  = fall_r;
endmodule // line_filter

// ===== src/dio_port.sv
// Design decisions made here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "dio_cfg.svh"
// Contract
// - Each input returns its level or detects any, rising or falling edges.
// - Falling mode flags only high-to-low moves, never low-to-high.
// - Edge counts only after new level lasts the filter width, 0 to 163 ms.
// - Edge-configured lines are sampled continuously and set a pending flag.
// - A pending edge is held until the next pending read, which returns it, or until its line's edge type changes.
// - Level reads keep edge state; a pending read or changing edge type clears pending.
// - Five isolated data lines are latched on each strobe rising edge.
// - Outputs can be forced low, high, toggled or follow a boolean source.
// - Enable lines are set, cleared or follow a source and gate outputs.
// - Per-enable polarity picks whether true or false source enables.
// - A source-driven output tracks its source until reassigned.

module dio_port #(
   parameter int N_IN      = 8,
   parameter int N_OUT     = 8,
   parameter int N_SRC     = 8,
   parameter int MS_CYCLES = `DIO_MS_CYCLES
) (
   input  wire logic              CLK,
   input  wire logic              RST_N,
   input  wire logic [7:0]        WB_ADR_I,
   input  wire logic [31:0]       WB_DAT_I,
   output logic      [31:0]       WB_DAT_O,
   input  wire logic [3:0]        WB_SEL_I,
   input  wire logic              WB_WE_I,
   input  wire logic              WB_STB_I,
   input  wire logic              WB_CYC_I,
   output logic                   WB_ACK_O,
   input  wire logic [N_IN-1:0]   DIN,
   input  wire logic [4:0]        ISO_DATA,
   input  wire logic              ISO_STROBE,
   input  wire logic [N_SRC-1:0]  BOOL_SRC,
   output logic      [N_OUT-1:0]  DOUT,
   output logic      [N_OUT-1:0]  DOUT_EN
);
   // Merge write data into a register under byte enables
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) r[8*b +: 8] = wd[8*b +: 8];
      end
      return r;
   endfunction

   // Pick a source bit with polarity from a 4-bit selector
   function automatic logic src_pick(input logic [3:0] sel, input logic [N_SRC-1:0] src,
                                     input logic pol);
      return src[sel[2:0]] ~^ pol;
   endfunction

   localparam int MS_W = $clog2(MS_CYCLES + 1);
   localparam logic [MS_W-1:0] MS_LAST = MS_W'(MS_CYCLES - 1);

   logic [MS_W-1:0] ms_cnt_r, ms_cnt_nxt;
   logic            ms_tick_r, ms_tick_nxt;

   // Millisecond enable pulse for the filters
   always_comb begin
      ms_tick_nxt = 1'b0;
      ms_cnt_nxt  = ms_cnt_r + MS_W'(1);
      if (ms_cnt_r == MS_LAST) begin
         ms_cnt_nxt  = '0;
         ms_tick_nxt = 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ms_cnt_r  <= '0;
         ms_tick_r <= 1'b0;
      end else begin
         ms_cnt_r  <= ms_cnt_nxt;
         ms_tick_r <= ms_tick_nxt;
      end
   end

   // Configuration and status state
   logic [31:0]      in_mode_r, in_mode_nxt;
   logic [7:0]       filt_r, filt_nxt, filt_eff;
   logic [N_IN-1:0]  pend_r, pend_nxt;
   logic [4:0]       iso_r, iso_nxt;
   logic [N_OUT-1:0] lvl_r, lvl_nxt;
   logic [31:0]      out_sel_r, out_sel_nxt;
   logic [N_OUT-1:0] out_pol_r, out_pol_nxt;
   logic [31:0]      en_sel_r, en_sel_nxt;
   logic [N_OUT-1:0] en_val_r, en_val_nxt;
   logic [N_OUT-1:0] en_pol_r, en_pol_nxt;
   logic [N_OUT-1:0] dout_r, dout_nxt, den_r, den_nxt;
   logic [31:0]      dat_r, dat_nxt;
   logic             ack_r, ack_nxt;

   logic [N_IN-1:0]  in_lvl, in_rise, in_fall, edge_set;
   logic [5:0]       iso_lvl, iso_rise;
   logic             req, wr, rd;
   logic [31:0]      wmask;

   // Filter width saturates at the longest allowed value
   assign filt_eff = (filt_r > 8'(`DIO_FILT_MAX_MS)) ? 8'(`DIO_FILT_MAX_MS) : filt_r;

   // One filter per digital input
   for (genvar i = 0; i < N_IN; i++) begin : g_in
      line_filter u_filt (
         .clk      (CLK),
         .rst_n    (RST_N),
         .pin      (DIN[i]),
         .ms_tick  (ms_tick_r),
         .width_ms (filt_eff),
         .level    (in_lvl[i]),
         .rise     (in_rise[i]),
         .fall     (in_fall[i])
      );
   end

   // Isolated data lines and strobe, synchronised without filtering
   for (genvar i = 0; i < 6; i++) begin : g_iso
      line_filter u_iso (
         .clk      (CLK),
         .rst_n    (RST_N),
         .pin      ((i == 5) ? ISO_STROBE : ISO_DATA[i % 5]),
         .ms_tick  (1'b0),
         .width_ms (8'h00),
         .level    (iso_lvl[i]),
         .rise     (iso_rise[i]),
         .fall     ()
      );
   end

   // Edge qualification per line mode
   always_comb begin
      for (int i = 0; i < N_IN; i++) begin
         case (dio_pkg::in_mode_t'(in_mode_r[2*i +: 2]))
            dio_pkg::IN_ANY_EDGE:  edge_set[i] = in_rise[i] | in_fall[i];
            dio_pkg::IN_RISE_EDGE: edge_set[i] = in_rise[i];
            dio_pkg::IN_FALL_EDGE: edge_set[i] = in_fall[i];
            default:               edge_set[i] = 1'b0;
         endcase
      end
   end

   assign req   = WB_CYC_I & WB_STB_I & ~ack_r;
   assign wr    = req & WB_WE_I;
   assign rd    = req & ~WB_WE_I;
   assign wmask = merge(32'h0000_0000, WB_DAT_I, WB_SEL_I);

   // Bus decode, register updates and line behaviour
   always_comb begin
      logic [31:0] w;
      logic [31:0] rsrc;
      w           = 32'h0000_0000;
      in_mode_nxt = in_mode_r;
      filt_nxt    = filt_r;
      out_sel_nxt = out_sel_r;
      out_pol_nxt = out_pol_r;
      en_sel_nxt  = en_sel_r;
      en_val_nxt  = en_val_r;
      en_pol_nxt  = en_pol_r;
      lvl_nxt     = lvl_r;
      iso_nxt     = iso_r;
      pend_nxt    = pend_r | edge_set;               // set wins
      rsrc        = 32'h0000_0000;
      ack_nxt     = req;
      dat_nxt     = 32'h0000_0000;

      if (iso_rise[5]) begin
         iso_nxt = iso_lvl[4:0];
      end

      if (wr && WB_ADR_I[7:2] == `DIO_OFS_IN_MODE >> 2) begin
         in_mode_nxt = merge(in_mode_r, WB_DAT_I, WB_SEL_I);
         for (int i = 0; i < N_IN; i++) begin
            if (in_mode_nxt[2*i +: 2] != in_mode_r[2*i +: 2]) begin
               pend_nxt[i] = edge_set[i];            // new mode restarts
            end
         end
      end else if (wr && WB_ADR_I[7:2] == `DIO_OFS_FILT_MS >> 2) begin
         w        = merge({24'h000000, filt_r}, WB_DAT_I, WB_SEL_I);
         filt_nxt = w[7:0];
      end else if (wr && WB_ADR_I[7:2] == `DIO_OFS_OUT_CMD >> 2) begin
         for (int i = 0; i < N_OUT; i++) begin
            case (dio_pkg::out_cmd_t'(wmask[2*i +: 2]))
               dio_pkg::CMD_LOW: begin
                  lvl_nxt[i] = 1'b0;
                  out_sel_nxt[4*i + `DIO_SEL_FOLLOW] = 1'b0;
               end
               dio_pkg::CMD_HIGH: begin
                  lvl_nxt[i] = 1'b1;
                  out_sel_nxt[4*i + `DIO_SEL_FOLLOW] = 1'b0;
               end
               dio_pkg::CMD_TOGGLE: begin
                  lvl_nxt[i] = ~lvl_r[i];
                  out_sel_nxt[4*i + `DIO_SEL_FOLLOW] = 1'b0;
               end
               default: begin
                  lvl_nxt[i] = lvl_r[i];
               end
            endcase
         end
      end else if (wr && WB_ADR_I[7:2] == `DIO_OFS_OUT_SEL >> 2) begin
         out_sel_nxt = merge(out_sel_r, WB_DAT_I, WB_SEL_I);
      end else if (wr && WB_ADR_I[7:2] == `DIO_OFS_OUT_POL >> 2) begin
         w           = merge(32'(out_pol_r), WB_DAT_I, WB_SEL_I);
         out_pol_nxt = w[N_OUT-1:0];
      end else if (wr && WB_ADR_I[7:2] == `DIO_OFS_EN_SEL >> 2) begin
         en_sel_nxt = merge(en_sel_r, WB_DAT_I, WB_SEL_I);
      end else if (wr && WB_ADR_I[7:2] == `DIO_OFS_EN_VAL >> 2) begin
         w          = merge(32'(en_val_r), WB_DAT_I, WB_SEL_I);
         en_val_nxt = w[N_OUT-1:0];
      end else if (wr && WB_ADR_I[7:2] == `DIO_OFS_EN_POL >> 2) begin
         w          = merge(32'(en_pol_r), WB_DAT_I, WB_SEL_I);
         en_pol_nxt = w[N_OUT-1:0];
      end

      // Read mux, unmapped addresses read zero
      if (WB_ADR_I[7:2] == `DIO_OFS_IN_MODE >> 2) begin
         rsrc = in_mode_r;
      end else if (WB_ADR_I[7:2] == `DIO_OFS_FILT_MS >> 2) begin
         rsrc = {24'h000000, filt_r};
      end else if (WB_ADR_I[7:2] == `DIO_OFS_IN_LEVEL >> 2) begin
         rsrc = 32'(in_lvl);                         // no side effect
      end else if (WB_ADR_I[7:2] == `DIO_OFS_EDGE_PEND >> 2) begin
         rsrc = 32'(pend_r);
         if (rd) begin
            pend_nxt = edge_set;                     // cleared, new edge kept
         end
      end else if (WB_ADR_I[7:2] == `DIO_OFS_ISO_LATCH >> 2) begin
         rsrc = {27'h0000000, iso_r};
      end else if (WB_ADR_I[7:2] == `DIO_OFS_OUT_SEL >> 2) begin
         rsrc = out_sel_r;
      end else if (WB_ADR_I[7:2] == `DIO_OFS_OUT_POL >> 2) begin
         rsrc = 32'(out_pol_r);
      end else if (WB_ADR_I[7:2] == `DIO_OFS_EN_SEL >> 2) begin
         rsrc = en_sel_r;
      end else if (WB_ADR_I[7:2] == `DIO_OFS_EN_VAL >> 2) begin
         rsrc = 32'(en_val_r);
      end else if (WB_ADR_I[7:2] == `DIO_OFS_EN_POL >> 2) begin
         rsrc = 32'(en_pol_r);
      end else if (WB_ADR_I[7:2] == `DIO_OFS_OUT_STATE >> 2) begin
         rsrc = 32'(dout_r) | (32'(den_r) << `DIO_OUT_STATE_EN);
      end
      if (rd) begin
         dat_nxt = rsrc;
      end

      // Output drive and enable gating
      for (int i = 0; i < N_OUT; i++) begin
         if (en_sel_r[4*i + `DIO_SEL_FOLLOW]) begin
            den_nxt[i] = src_pick(en_sel_r[4*i +: 4], BOOL_SRC, en_pol_r[i]);
         end else begin
            den_nxt[i] = en_val_r[i];
         end
         if (out_sel_r[4*i + `DIO_SEL_FOLLOW]) begin
            dout_nxt[i] = src_pick(out_sel_r[4*i +: 4], BOOL_SRC, out_pol_r[i]);
         end else begin
            dout_nxt[i] = lvl_r[i];
         end
         dout_nxt[i] = dout_nxt[i] & den_nxt[i];
      end
   end

   // Register everything
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         in_mode_r <= `DIO_RST_WORD;
         filt_r    <= `DIO_RST_FILT;
         pend_r    <= '0;
         iso_r     <= 5'h00;
         lvl_r     <= '0;
         out_sel_r <= `DIO_RST_WORD;
         out_pol_r <= '0;
         en_sel_r  <= `DIO_RST_WORD;
         en_val_r  <= '0;
         en_pol_r  <= '0;
         dout_r    <= '0;
         den_r     <= '0;
         dat_r     <= 32'h0000_0000;
         ack_r     <= 1'b0;
      end else begin
         in_mode_r <= in_mode_nxt;
         filt_r    <= filt_nxt;
         pend_r    <= pend_nxt;
         iso_r     <= iso_nxt;
         lvl_r     <= lvl_nxt;
         out_sel_r <= out_sel_nxt;
         out_pol_r <= out_pol_nxt;
         en_sel_r  <= en_sel_nxt;
         en_val_r  <= en_val_nxt;
         en_pol_r  <= en_pol_nxt;
         dout_r    <= dout_nxt;
         den_r     <= den_nxt;
         dat_r     <= dat_nxt;
         ack_r     <= ack_nxt;
      end
   end

   assign WB_DAT_O = dat_r;
   assign WB_ACK_O = ack_r;
   assign DOUT     = dout_r;
   assign DOUT_EN  = den_r;
endmodule // dio_port

// ===== testbench/dio_port_monitor.sv
`timescale 1ns/100ps
// Bus handshake and output causality checks
module dio_port_monitor #(
   parameter int N_OUT = 8,
   parameter int N_SRC = 8
) (
   input wire logic             CLK,
   input wire logic             RST_N,
   input wire logic [31:0]      WB_DAT_O,
   input wire logic             WB_WE_I,
   input wire logic             WB_STB_I,
   input wire logic             WB_CYC_I,
   input wire logic             WB_ACK_O,
   input wire logic [N_SRC-1:0] BOOL_SRC,
   input wire logic [N_OUT-1:0] DOUT,
   input wire logic [N_OUT-1:0] DOUT_EN
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // Handshake shape
   ack_one_cycle_a: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack held too long");
   ack_on_take_a: assert property ((WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O)
      else $error("request not acked");
   ack_cause_a: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
      else $error("ack without request");
   idle_no_ack_a: assert property (!WB_CYC_I |=> !WB_ACK_O)
      else $error("ack while idle");
   dat_quiet_a: assert property (!WB_ACK_O |-> WB_DAT_O == '0)
      else $error("read data outside ack");
   // Output gating and causes of change
   out_gated_a: assert property ((DOUT & ~DOUT_EN) == '0)
      else $error("output high while disabled");
   dout_cause_a: assert property (!$stable(DOUT) |->
      $past(WB_ACK_O && WB_WE_I) || $past(WB_ACK_O && WB_WE_I, 2) ||
      $past(BOOL_SRC) != $past(BOOL_SRC, 3))
      else $error("output moved without cause");
   en_cause_a: assert property (!$stable(DOUT_EN) |->
      $past(WB_ACK_O && WB_WE_I) || $past(WB_ACK_O && WB_WE_I, 2) ||
      $past(BOOL_SRC) != $past(BOOL_SRC, 3))
      else $error("enable moved without cause");
endmodule // dio_port_monitor

bind dio_port dio_port_monitor #(.N_OUT(N_OUT), .N_SRC(N_SRC)) dio_port_monitor_i (
   .CLK(CLK), .RST_N(RST_N), .WB_DAT_O(WB_DAT_O), .WB_WE_I(WB_WE_I),
   .WB_STB_I(WB_STB_I), .WB_CYC_I(WB_CYC_I), .WB_ACK_O(WB_ACK_O),
   .BOOL_SRC(BOOL_SRC), .DOUT(DOUT), .DOUT_EN(DOUT_EN));

// ===== testbench/dio_field.sv
`timescale 1ns/100ps
// Sensors on the input lines and a strobed isolated source
module dio_field (
   input  wire logic       clk,
   output logic      [7:0] din,
   output logic      [4:0] iso_data,
   output logic            iso_strobe
);
   // Quiet lines at start
   initial begin
      din = '0;
      iso_data = '0;
      iso_strobe = 1'b0;
   end
   // New sensor levels
   task automatic set_din(input logic [7:0] v);
      @(posedge clk);
      din <= v;
   endtask
   // Data set up, strobe pulse, then data released
   task automatic strobe(input logic [4:0] d);
      @(posedge clk);
      iso_data <= d;
      repeat (3) @(posedge clk);
      iso_strobe <= 1'b1;
      repeat (6) @(posedge clk);
      iso_strobe <= 1'b0;
      repeat (6) @(posedge clk);
      iso_data <= ~d; // No stale value once released
   endtask
endmodule // dio_field

// ===== testbench/test_dio_port.sv
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
   $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module test_dio_port;
   logic        clk;
   logic        rst_n;
   logic [7:0]  adr;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic [31:0] q;
   logic        we;
   logic        stb;
   logic        cyc;
   logic [3:0]  sel;
   logic        ack;
   logic [7:0]  din;
   logic [4:0]  iso_d;
   logic        iso_s;
   logic [7:0]  src;
   logic [7:0]  dout;
   logic [7:0]  dout_en;
   int          n_mismatch;
   int          cmp_count;
   logic [1:0]  cmds [5] = '{2'h2, 2'h3, 2'h3, 2'h0, 2'h1};
   logic        outs [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

   dio_port #(.MS_CYCLES(4)) dio_port_i (
      .CLK(clk), .RST_N(rst_n), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
      .WB_SEL_I(sel), .WB_WE_I(we), .WB_STB_I(stb), .WB_CYC_I(cyc), .WB_ACK_O(ack),
      .DIN(din), .ISO_DATA(iso_d), .ISO_STROBE(iso_s), .BOOL_SRC(src),
      .DOUT(dout), .DOUT_EN(dout_en));
   dio_field dio_field_i (.clk(clk), .din(din), .iso_data(iso_d), .iso_strobe(iso_s));

   // Clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Counts and verdict
   task automatic conclude();
      $display("Mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // One classic cycle, bounded wait for ack
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= s;
      adr <= a;
      wdat <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 64);
      if (n >= 64) begin
         n_mismatch++;
         conclude();
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask
   // Write through selected byte lanes only
   task automatic wr_lanes(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      bus(1'b1, a, d, s);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, '0, 4'hF);
      `CHK(q, e)
   endtask

   // Main sequence
   initial begin
      rst_n = 1'b0;
      {cyc, stb, we, adr, wdat, src} = '0;
      sel = 4'hF;
      n_mismatch = 0;
      cmp_count = 0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      rd(8'h00, '0);
      wr(8'h2C, '1);
      rd(8'h2C, '0);
      wr(8'h3C, '1);
      rd(8'h3C, '0);
      // Byte lanes: only lane 0 holds the enable polarity bits
      wr_lanes(8'h28, 32'h0000_5A3C, 4'h2);
      rd(8'h28, 32'h0);
      wr_lanes(8'h28, 32'h0000_5A3C, 4'h1);
      rd(8'h28, 32'h3C);
      // Fixed commands on line 0
      wr(8'h24, 32'hFF);
      for (int i = 0; i < 5; i++) begin
         wr(8'h14, {30'h0, cmds[i]});
         repeat (3) @(posedge clk);
         `CHK(dout[0], outs[i])
      end
      `CHK(dout_en, 8'hFF)
      // Line 0 follows source 2, both polarities
      wr(8'h18, 32'hA);
      for (int p = 0; p < 2; p++) begin
         wr(8'h1C, 32'(p));
         for (int v = 0; v < 2; v++) begin
            src[2] <= v[0];
            repeat (3) @(posedge clk);
            `CHK(dout[0], v[0] ~^ p[0])
         end
      end
      wr(8'h14, 32'h1);
      src[2] <= 1'b0;
      repeat (3) @(posedge clk);
      src[2] <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK(dout[0], 1'b0)
      // Enable of line 1 follows source 3
      wr(8'h14, 32'h8);
      wr(8'h20, 32'hB0);
      for (int p = 0; p < 2; p++) begin
         wr(8'h28, 32'(p << 1));
         for (int v = 0; v < 2; v++) begin
            src[3] <= v[0];
            repeat (3) @(posedge clk);
            `CHK(dout_en[1], v[0] ~^ p[0])
            `CHK(dout[1], v[0] ~^ p[0])
         end
      end
      // Output state: line 1 high and enabled, all enables on
      rd(8'h2C, 32'h0000_FF02);
      // Isolated port latch
      dio_field_i.strobe(5'h15);
      rd(8'h10, 32'h15);
      dio_field_i.strobe(5'h0A);
      rd(8'h10, 32'h0A);
      // Lines 0..3: level, any, rising, falling; 2 ms filter
      wr(8'h04, 32'h2);
      wr(8'h00, 32'hE4);
      dio_field_i.set_din(8'h0F);
      repeat (40) @(posedge clk);
      rd(8'h08, 32'hF);
      rd(8'h0C, 32'h6);
      rd(8'h0C, 32'h0);
      dio_field_i.set_din(8'h00);
      repeat (40) @(posedge clk);
      rd(8'h08, 32'h0);
      rd(8'h0C, 32'hA);
      // Short pulse dropped
      dio_field_i.set_din(8'h0F);
      repeat (2) @(posedge clk);
      dio_field_i.set_din(8'h00);
      repeat (40) @(posedge clk);
      rd(8'h0C, 32'h0);
      // New edge type on line 1 drops its pending edge
      dio_field_i.set_din(8'h0F);
      repeat (40) @(posedge clk);
      wr(8'h00, 32'hEC);
      rd(8'h0C, 32'h4);
      conclude();
   end
endmodule // test_dio_port
